// ---- sysctl_chk.sv ----
`timescale 1ns/100ps
`include "sysctl_defs.svh"
// ----
// port checker
// ----
module sysctl_chk import sysctl_pkg::*; #(
    parameter int unsigned PSM_TIMEOUT = 20
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq,
    input wire ctrl_out_t ctrl_out,
    input wire logic soft_reset_pulse,
    input wire logic psm_blocks_up,
    input wire logic psm_proceed,
    input wire logic copy_busy,
    input wire logic ram_wr_en,
    input wire logic debug_clock_pin_en,
    input wire logic debug_data_pin_en,
    input wire logic [3:0] debug_data_pin_sel
);
    wire logic ctrl_wr;
    assign ctrl_wr = wr && addr == `ADDR_SYS_CTRL;
    default clocking chk_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata set without read");
    ctrl_pad_a: assert property (rd && addr == `ADDR_SYS_CTRL |=> rdata[31:11] == 21'h0 && !rdata[3])
        else $error("control pad bits read nonzero");
    stat_pad_a: assert property (rd && addr == `ADDR_SYS_STAT |=> rdata[31:8] == 24'h0 && !rdata[5])
        else $error("status pad bits read nonzero");
    ctrl_load_a: assert property (ctrl_wr && !wdata[15] ##1 !wr |=> ctrl_out.dbg_map == $past(wdata[8:7], 2)
        && ctrl_out.otp_ctrl_rst_request == $past(wdata[6], 2) && ctrl_out.timeout_disable == $past(wdata[10], 2))
        else $error("control fields not loaded");
    dbg_release_a: assert property ((ctrl_out.dbg_map == 2'h0) [*2] |-> !debug_clock_pin_en && !debug_data_pin_en)
        else $error("debug pins held while disabled");
    dbg_map_a: assert property ((ctrl_out.dbg_map == 2'h3) [*2] |-> debug_data_pin_sel == 4'ha && debug_clock_pin_en)
        else $error("debug map three wrong");
    soft_pulse_a: assert property (ctrl_wr && wdata[15] |=> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    boot_hold_a: assert property (!$past(ctrl_wr && wdata[15]) && !$past(soft_reset_pulse)
        |-> $stable(ctrl_out.boot_memory_select)) else $error("boot select moved without soft reset");
    ramwr_busy_a: assert property (ram_wr_en |-> copy_busy) else $error("ram write outside copy");
    psm_hold_a: assert property ((ctrl_out.timeout_disable && !psm_blocks_up) [*2] |-> !psm_proceed)
        else $error("proceed with timeout disabled");
    copy_len_a: assert property ($rose(copy_busy) |-> copy_busy [*8]) else $error("copy too short");
    cover property (soft_reset_pulse);
    cover property (ram_wr_en);
    cover property (psm_proceed);
    cover property (irq);
endmodule
bind system_control_status_regs sysctl_chk #(.PSM_TIMEOUT(PSM_TIMEOUT)) u_sysctl_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .ctrl_out(ctrl_out), .soft_reset_pulse(soft_reset_pulse), .psm_blocks_up(psm_blocks_up),
    .psm_proceed(psm_proceed), .copy_busy(copy_busy), .ram_wr_en(ram_wr_en),
    .debug_clock_pin_en(debug_clock_pin_en), .debug_data_pin_en(debug_data_pin_en),
    .debug_data_pin_sel(debug_data_pin_sel));

// ---- sysctl_defs.svh ----
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH
// Contract
// R1 - writing one to control bit 15 resets everything except the control register and the trim target; the code also keeps soft_reset_pulse.
// R2 - the power state machine moves on after 2 ms without startup unless control bit 10 removes that timeout.
// R3 - control bits 8:7 select the debug pin map: 0 off, 1..3 clock on pin 2 and data on pin 5, 1 or 10.
// R4 - with the debug field at zero the debug clock and data pins are released to general-purpose use.
// R5 - control bit 6 drives a reset request to the otp controller while it is set.
// R6 - control bit 4 set makes the device copy otp into system ram at every system domain wakeup.
// R7 - emulation bit 2 with copy set runs the copy for its full duration without ram writes.
// R8 - emulation bit clear with copy set makes the copy really write system ram.
// R9 - control bits 1:0 choose the memory at address zero: rom, otp, first ram, third ram at 28 kbytes offset.
// R10 - a new boot memory selection takes effect only at the next software reset.
// R11 - status bit 7 goes high once the fast crystal has run for the programmed settle time.
// R12 - status bit 6 reads one while the applied trim equals the target trim, and resets to one.
// R13 - status bit 4 reads one while a serial-wire debugger is attached to the core.
// R14 - status bits 3 and 2 flag the timer domain on and off; bit 2 resets to one.
// R15 - status bits 1 and 0 flag the radio domain on and off; bit 0 resets to one.
// R16 - the settle-count field counts in units of 64 crystal clock cycles.
// R17 - status writes are ignored and the software reset bit reads as zero.

// ------------------------------
// register map
// ------------------------------
`define ADDR_SYS_CTRL 32'h5000_0012
`define ADDR_SYS_STAT 32'h5000_0014
`define ADDR_IRQ_MASK 32'h5000_0040
`define CTRL_RESET 16'h0020
`define CTRL_WMASK 16'h07f7
`define STAT_RESET 8'h45
`define STAT_USED 8'hdf
`define BIT_SOFT_RESET 15
`define BIT_TIMEOUT_DIS 10
`define BIT_OTP_RST 6
`define BIT_COPY 4
`define BIT_EMUL 2
// ------------------------------
// timing
// ------------------------------
`define CLK_MHZ 40
`define PSM_TIMEOUT_US 2000
`define PSM_TIMEOUT_CYC (`PSM_TIMEOUT_US * `CLK_MHZ)
`define SETTLE_UNIT 64
`define COPY_CYCLES 16'h0800
`endif

// ---- sysctl_pkg.sv ----
package sysctl_pkg;
    typedef struct packed {
        logic [1:0] dbg_map;
        logic [1:0] boot_memory_select;
        logic otp_ctrl_rst_request;
        logic timeout_disable;
    } ctrl_out_t;
    typedef enum logic [1:0] {
        CP_IDLE = 2'b00,
        CP_RUN = 2'b01,
        CP_DONE = 2'b11
    } copy_state_t;
    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_WAIT = 2'b01,
        PS_GO = 2'b11
    } psm_state_t;
endpackage

// ---- system_control_status_regs.sv ----
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "sysctl_defs.svh"
module system_control_status_regs import sysctl_pkg::*; #(
    parameter int unsigned PSM_TIMEOUT = `PSM_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    output ctrl_out_t ctrl_out,
    output logic soft_reset_pulse,
    input wire logic xtal_clk_tick,
    input wire logic xtal_running,
    input wire logic [5:0] settle_count,
    input wire logic [7:0] trim_applied,
    input wire logic [7:0] crystal_trim_target,
    input wire logic debugger_attached,
    input wire logic timer_domain_on,
    input wire logic timer_domain_off,
    input wire logic radio_domain_on,
    input wire logic radio_domain_off,
    input wire logic system_power_domain_wake,
    input wire logic psm_start,
    input wire logic psm_blocks_up,
    output logic psm_proceed,
    output logic copy_busy,
    output logic ram_wr_en,
    output logic [15:0] ram_wr_addr,
    output logic debug_clock_pin_en,
    output logic debug_data_pin_en,
    output logic [3:0] debug_data_pin_sel
);
    // ------------------------------
    // decode
    // ------------------------------
    logic [15:0] ctrl_r;
    logic [7:0] stat_mask_r;
    logic [7:0] stat_sticky_r;
    logic [1:0] boot_r;
    logic [11:0] settle_cnt_r;
    logic [5:0] tick_cnt_r;
    logic settled_r;
    logic [31:0] psm_cnt_r;
    psm_state_t psm_r;
    copy_state_t cp_r;
    logic [15:0] cp_cnt_r;
    wire sel_ctrl = addr == `ADDR_SYS_CTRL;
    wire sel_stat = addr == `ADDR_SYS_STAT;
    wire sel_mask = addr == `ADDR_IRQ_MASK;
    wire ctrl_wr = wr && sel_ctrl;
    // the control register and soft reset pulse survive a software reset; boot select loads from the write
    wire soft_rst = ctrl_wr && wdata[`BIT_SOFT_RESET]; // R1
    wire local_rst = !rst_b || soft_rst; // R1
    wire trim_ok = trim_applied == crystal_trim_target; // R12
    wire [7:0] stat_now = {settled_r, trim_ok, 1'b0, debugger_attached, // R11 R13
                           timer_domain_on, timer_domain_off, // R14
                           radio_domain_on, radio_domain_off}; // R15
    wire [7:0] stat_rise = stat_now & ~stat_sticky_r;
    wire [31:0] rd_mux = sel_ctrl ? {16'h0000, 1'b0, ctrl_r[14:0]} : // R17
                         sel_stat ? {24'h000000, stat_now} :
                         sel_mask ? {24'h000000, stat_mask_r} : 32'h0000_0000;
    wire [11:0] settle_target = {settle_count, 6'h00}; // R16
    wire [1:0] dbg_field = ctrl_r[8:7];
    wire dbg_on = dbg_field != 2'b00; // R4
    wire timeout_hit = psm_cnt_r >= PSM_TIMEOUT - 1;
    wire copy_done = cp_cnt_r == `COPY_CYCLES - 16'h0001;

    function automatic logic [3:0] dio_pin(input logic [1:0] code);
        case (code)
            2'b01: dio_pin = 4'h5;
            2'b10: dio_pin = 4'h1;
            2'b11: dio_pin = 4'ha;
            default: dio_pin = 4'h0;
        endcase
    endfunction

    // ------------------------------
    // registers
    // ------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_r <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= wdata[15:0] & `CTRL_WMASK; // R17
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            boot_r <= 2'b00;
        end else if (soft_rst) begin
            boot_r <= wdata[1:0]; // R9 R10
        end
    end

    always_ff @(posedge sys_clk) begin
        if (local_rst) begin
            stat_mask_r <= 8'h00;
        end else if (wr && sel_mask) begin
            stat_mask_r <= wdata[7:0];
        end
    end

    // sticky level events; read clears, new event wins
    always_ff @(posedge sys_clk) begin
        if (local_rst) begin
            stat_sticky_r <= `STAT_RESET;
        end else if (rd && sel_stat) begin
            stat_sticky_r <= stat_now & `STAT_USED;
        end else begin
            stat_sticky_r <= (stat_sticky_r | stat_now) & `STAT_USED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (local_rst) begin
            rdata <= 32'h0000_0000;
            irq <= 1'b0;
            ctrl_out <= '0;
            debug_clock_pin_en <= 1'b0;
            debug_data_pin_en <= 1'b0;
            debug_data_pin_sel <= 4'h0;
        end else begin
            rdata <= rd ? rd_mux : 32'h0000_0000;
            irq <= |((stat_sticky_r | stat_rise) & stat_mask_r);
            ctrl_out <= '{dbg_map: dbg_field, boot_memory_select: boot_r, // R9
                          otp_ctrl_rst_request: ctrl_r[`BIT_OTP_RST], // R5
                          timeout_disable: ctrl_r[`BIT_TIMEOUT_DIS]}; // R2
            debug_clock_pin_en <= dbg_on; // R3 R4
            debug_data_pin_en <= dbg_on; // R3 R4
            debug_data_pin_sel <= dio_pin(dbg_field); // R3
        end
    end

    // pulse must survive the reset it announces
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_rst; // R1
        end
    end

    // ------------------------------
    // crystal settle
    // ------------------------------
    // counted on crystal ticks; restarts whenever the crystal stops
    always_ff @(posedge sys_clk) begin
        if (local_rst || !xtal_running) begin
            tick_cnt_r <= 6'h00;
            settle_cnt_r <= 12'h000;
            settled_r <= 1'b0;
        end else if (xtal_clk_tick && !settled_r) begin
            tick_cnt_r <= tick_cnt_r + 6'h01;
            settle_cnt_r <= settle_cnt_r + 12'h001; // R16
            settled_r <= settle_cnt_r + 12'h001 >= settle_target; // R11
        end
    end

    // ------------------------------
    // power state timeout
    // ------------------------------
    always_ff @(posedge sys_clk) begin
        if (local_rst) begin
            psm_r <= PS_IDLE;
            psm_cnt_r <= 32'h0000_0000;
            psm_proceed <= 1'b0;
        end else begin
            case (psm_r)
                PS_IDLE: begin
                    psm_proceed <= 1'b0;
                    psm_cnt_r <= 32'h0000_0000;
                    if (psm_start) begin
                        psm_r <= PS_WAIT;
                    end
                end
                PS_WAIT: begin
                    psm_cnt_r <= psm_cnt_r + 32'h0000_0001;
                    if (psm_blocks_up || (timeout_hit && !ctrl_r[`BIT_TIMEOUT_DIS])) begin // R2
                        psm_r <= PS_GO;
                        psm_proceed <= 1'b1;
                    end
                end
                PS_GO: begin
                    psm_proceed <= 1'b0;
                    psm_r <= PS_IDLE;
                end
                default: psm_r <= PS_IDLE;
            endcase
        end
    end

    // ------------------------------
    // otp mirror
    // ------------------------------
    // emulation keeps identical timing so boot time matches real mirroring
    always_ff @(posedge sys_clk) begin
        if (local_rst) begin
            cp_r <= CP_IDLE;
            cp_cnt_r <= 16'h0000;
            copy_busy <= 1'b0;
            ram_wr_en <= 1'b0;
            ram_wr_addr <= 16'h0000;
        end else begin
            case (cp_r)
                CP_IDLE: begin
                    cp_cnt_r <= 16'h0000;
                    ram_wr_en <= 1'b0;
                    if (system_power_domain_wake && ctrl_r[`BIT_COPY]) begin // R6
                        cp_r <= CP_RUN;
                        copy_busy <= 1'b1;
                        cp_cnt_r <= 16'h0001;
                        ram_wr_addr <= 16'h0000;
                        ram_wr_en <= !ctrl_r[`BIT_EMUL]; // R7 R8
                    end
                end
                CP_RUN: begin
                    cp_cnt_r <= cp_cnt_r + 16'h0001;
                    ram_wr_addr <= cp_cnt_r;
                    ram_wr_en <= !ctrl_r[`BIT_EMUL]; // R7 R8
                    if (copy_done) begin
                        cp_r <= CP_DONE;
                    end
                end
                CP_DONE: begin
                    ram_wr_en <= 1'b0;
                    copy_busy <= 1'b0;
                    cp_r <= CP_IDLE;
                end
                default: cp_r <= CP_IDLE;
            endcase
        end
    end
endmodule

// ---- test_system_control_status_regs.sv ----
`timescale 1ns/100ps
`include "sysctl_defs.svh"
// ----
// bench
// ----
module test_system_control_status_regs import sysctl_pkg::*;;
    logic sys_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, xtal_clk_tick = 1'b1, xtal_running = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d, r;
    logic [5:0] settle_count = 6'h02;
    logic [7:0] trim_applied = 8'h11, crystal_trim_target = 8'h11;
    logic debugger_attached = 1'b0, timer_domain_on = 1'b0, timer_domain_off = 1'b1;
    logic radio_domain_on = 1'b0, radio_domain_off = 1'b1, settled = 1'b0;
    logic system_power_domain_wake = 1'b0, psm_start = 1'b0, psm_blocks_up = 1'b0;
    logic irq, soft_reset_pulse, psm_proceed, copy_busy, ram_wr_en, debug_clock_pin_en, debug_data_pin_en;
    logic [15:0] ram_wr_addr;
    logic [3:0] debug_data_pin_sel;
    ctrl_out_t ctrl_out;
    int err_total = 0, tests_run = 0, n, m, k;
    system_control_status_regs #(.PSM_TIMEOUT(20)) u_system_control_status_regs (.*);
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] stat_exp();
        return {24'h0, settled, trim_applied == crystal_trim_target, 1'b0, debugger_attached,
            timer_domain_on, timer_domain_off, radio_domain_on, radio_domain_off};
    endfunction
    function automatic logic [3:0] sel_exp(input logic [1:0] c);
        return (c == 2'h1) ? 4'h5 : (c == 2'h2) ? 4'h1 : (c == 2'h3) ? 4'ha : 4'h0;
    endfunction
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic psm_try(input int lim, input logic e);
        @(posedge sys_clk) psm_start <= 1'b1;
        @(posedge sys_clk) psm_start <= 1'b0;
        for (n = 0; n < lim && psm_proceed !== 1'b1; n++) @(negedge sys_clk);
        check("psm_proceed", psm_proceed, e);
    endtask
    initial begin
        void'($urandom(32'h67252ef2));
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_reg(`ADDR_SYS_CTRL, r);
        check("ctrl_reset", r, 32'h20);
        rd_reg(`ADDR_SYS_STAT, r);
        check("stat_reset", r, 32'h45);
        repeat (8) begin
            @(posedge sys_clk);
            {debugger_attached, timer_domain_on, timer_domain_off, radio_domain_on, radio_domain_off} <= 5'($urandom);
            trim_applied <= $urandom_range(1) ? crystal_trim_target : 8'($urandom);
            rd_reg(`ADDR_SYS_STAT, r);
            check("stat_live", r, stat_exp());
        end
        wr_reg(`ADDR_SYS_STAT, 32'hff);
        rd_reg(`ADDR_SYS_STAT, r);
        check("stat_ro", r, stat_exp());
        for (k = 0; k < 4; k++) begin
            d = ($urandom & 32'h7e7f) | (k << 7);
            wr_reg(`ADDR_SYS_CTRL, d);
            rd_reg(`ADDR_SYS_CTRL, r);
            check("ctrl_rw", r, d & 32'h07f7);
            check("dbg", {debug_data_pin_sel, debug_data_pin_en, ctrl_out}, {sel_exp(k), k != 0, k[1:0], 2'h0, d[6], d[10]});
        end
        @(posedge sys_clk) xtal_running <= 1'b1;
        repeat (100) @(posedge sys_clk);
        rd_reg(`ADDR_SYS_STAT, r);
        check("not_settled", r, stat_exp());
        repeat (40) @(posedge sys_clk);
        settled = 1'b1;
        rd_reg(`ADDR_SYS_STAT, r);
        check("settled", r, stat_exp());
        @(posedge sys_clk) debugger_attached <= 1'b0;
        wr_reg(`ADDR_IRQ_MASK, 32'h10);
        rd_reg(`ADDR_SYS_STAT, r);
        @(posedge sys_clk) debugger_attached <= 1'b1;
        @(posedge sys_clk) debugger_attached <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check("irq_set", irq, 1'b1);
        rd_reg(`ADDR_SYS_STAT, r);
        repeat (3) @(posedge sys_clk);
        #1 check("irq_clear", irq, 1'b0);
        rd_reg(32'h5000_0030, r);
        check("unmapped", r, 32'h0);
        for (k = 0; k < 4; k++) begin
            wr_reg(`ADDR_SYS_CTRL, 32'h8000 | k);
            repeat (3) @(posedge sys_clk);
            rd_reg(`ADDR_IRQ_MASK, r);
            check("soft_rst", {r, ctrl_out.boot_memory_select}, {32'h0, k[1:0]});
        end
        wr_reg(`ADDR_SYS_CTRL, 32'h0);
        psm_try(40, 1'b1);
        wr_reg(`ADDR_SYS_CTRL, 32'h400);
        psm_try(60, 1'b0);
        @(posedge sys_clk) psm_blocks_up <= 1'b1;
        for (n = 0; n < 5 && psm_proceed !== 1'b1; n++) @(negedge sys_clk);
        check("psm_up", psm_proceed, 1'b1);
        psm_blocks_up <= 1'b0;
        for (k = 0; k < 2; k++) begin
            wr_reg(`ADDR_SYS_CTRL, k ? 32'h14 : 32'h10);
            @(posedge sys_clk) system_power_domain_wake <= 1'b1;
            @(posedge sys_clk) system_power_domain_wake <= 1'b0;
            n = 0;
            m = 0;
            repeat (2100) @(negedge sys_clk) begin
                n += copy_busy;
                m += ram_wr_en;
            end
            check("copy_len", n, `COPY_CYCLES);
            check("ram_wr", m != 0, !k);
        end
        conclude();
    end
endmodule
